// ==== hw/lnbc_pkg.sv ====
// How it works
// - pin control: output on while enable pin high, off (zero volts) while low.
// - register accesses work whatever the enable pin level.
// - control source bit 1 takes enable from the register enable bit.
// - control source bit resets to 0, leaving the enable pin in charge.
// - pin control, enable high: SCL and voltage-select pins pick one of four levels.
// - control source bit 1: level from the 4-bit code, pins ignored, even enable low.
// - register enable bit resets to 1.
// - slave works at 100 kbps and 400 kbps with one protocol.
// - only 7-bit addressing; no 10-bit, no general call.
// - slave address picked from the four address pin levels.
// - slave acknowledges its address and each byte it receives by holding SDA low through the next clock pulse; read bytes get the master's acknowledge.
// - data byte is committed at the falling SCL edge of its last bit.
// - 4-bit code maps 0000 to 11 V up to 1111 at 20 V in 0.6 V steps.
`default_nettype none

package lnbc_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] REG_CTRL1_OFFSET  = 8'h00;
    localparam logic [7:0] REG_CTRL2_OFFSET  = 8'h01;
    localparam logic [7:0] REG_STATUS_OFFSET = 8'h02;

    localparam logic [7:0] CTRL1_RESET = 8'h08;
    localparam logic [7:0] CTRL2_RESET = 8'h09;

    localparam int CTRL1_SRC_BIT   = 7;
    localparam int CTRL1_CODE_LSB  = 1;
    localparam int CTRL2_EN_BIT    = 3;
    localparam int CODE_W          = 4;

    // ==========================================================
    // voltage codes chosen by the pins (scl, voltage select)
    localparam logic [3:0] CODE_PIN_HH = 4'h0e;
    localparam logic [3:0] CODE_PIN_HL = 4'h06;
    localparam logic [3:0] CODE_PIN_LH = 4'h0c;
    localparam logic [3:0] CODE_PIN_LL = 4'h04;

    // ==========================================================
    // slave address by address pin level code
    localparam logic [1:0] ADDR_PIN_VCC   = 2'h0;
    localparam logic [1:0] ADDR_PIN_FLOAT = 2'h1;
    localparam logic [1:0] ADDR_PIN_GND   = 2'h2;
    localparam logic [1:0] ADDR_PIN_MID   = 2'h3;

    localparam logic [6:0] SLAVE_ADDR_VCC   = 7'h08;
    localparam logic [6:0] SLAVE_ADDR_FLOAT = 7'h09;
    localparam logic [6:0] SLAVE_ADDR_GND   = 7'h10;
    localparam logic [6:0] SLAVE_ADDR_MID   = 7'h11;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ==========================================================
    // serial engine states
    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ACK_ADDR = 9'h004,
        ST_REG      = 9'h008,
        ST_ACK_REG  = 9'h010,
        ST_WDATA    = 9'h020,
        ST_ACK_DATA = 9'h040,
        ST_TX       = 9'h080,
        ST_MACK     = 9'h100
    } lnbc_state_type;

endpackage

`default_nettype wire

// ==== hw/lnbc_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module lnbc_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // ==========================================================
    // two stage synchroniser, idle-high reset for bus lines
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q   <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ==== hw/lnbc_output_select.sv ====
`timescale 1ns/100ps
`default_nettype none

module lnbc_output_select
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       enable_pin,
    input  wire logic       scl_level,
    input  wire logic       voltage_select_pin,
    input  wire logic       control_source_select,
    input  wire logic       reg_enable,
    input  wire logic [3:0] reg_code,
    output var  logic       regulated_output_enable,
    output var  logic [3:0] output_voltage_code
);

    import lnbc_pkg::*;

    logic       en_d;
    logic [3:0] code_d;
    logic [3:0] pin_code;

    // ==========================================================
    // pin level table
    always_comb
    begin
        case ({scl_level, voltage_select_pin})
            2'h3:    pin_code = CODE_PIN_HH;
            2'h2:    pin_code = CODE_PIN_HL;
            2'h1:    pin_code = CODE_PIN_LH;
            default: pin_code = CODE_PIN_LL;
        endcase
    end

    // ==========================================================
    // source choice
    always_comb
    begin
        if (control_source_select)
        begin
            en_d   = reg_enable;
            code_d = reg_code;
        end
        else
        begin
            en_d   = enable_pin;
            code_d = pin_code;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regulated_output_enable <= 1'b0;
            output_voltage_code     <= CTRL1_RESET[CTRL1_CODE_LSB +: CODE_W];
        end
        else
        begin
            regulated_output_enable <= en_d;
            output_voltage_code     <= code_d;
        end
    end

endmodule

`default_nettype wire

// ==== hw/lnbc_i2c_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module lnbc_i2c_top
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_out,
    output var  logic       sda_oe,
    input  wire logic       enable_pin,
    input  wire logic       voltage_select_pin,
    input  wire logic [1:0] address_pin_level,
    input  wire logic [6:0] status_in,
    output var  logic       regulated_output_enable,
    output var  logic [3:0] output_voltage_code,
    output var  logic       control_source_select,
    output var  logic [7:0] ctrl1_value,
    output var  logic [7:0] ctrl2_value
);

    import lnbc_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [3:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       en_s;
    logic       vsel_s;
    logic [1:0] addr_lvl_s;

    // enable travels inverted so the idle-high reset reads it as low
    lnbc_sync #(.WIDTH(4)) u_pin_sync
    (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({scl_in, sda_in, ~enable_pin, voltage_select_pin}),
        .sync_out (pins_s)
    );

    lnbc_sync #(.WIDTH(2)) u_addr_sync
    (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (address_pin_level),
        .sync_out (addr_lvl_s)
    );

    assign scl_s  = pins_s[3];
    assign sda_s  = pins_s[2];
    assign en_s   = ~pins_s[1];
    assign vsel_s = pins_s[0];

    // ==========================================================
    // bus edges and conditions
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // oversampled edges work for both bus speeds
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    // ==========================================================
    // own address from address pin level
    logic [6:0] own_addr;

    always_comb
    begin
        case (addr_lvl_s)
            ADDR_PIN_VCC:   own_addr = SLAVE_ADDR_VCC;
            ADDR_PIN_FLOAT: own_addr = SLAVE_ADDR_FLOAT;
            ADDR_PIN_GND:   own_addr = SLAVE_ADDR_GND;
            ADDR_PIN_MID:   own_addr = SLAVE_ADDR_MID;
            default:        own_addr = SLAVE_ADDR_VCC;
        endcase
    end

    // ==========================================================
    // serial engine
    lnbc_state_type state_q;
    lnbc_state_type state_d;
    logic [3:0]     cnt_q;
    logic [7:0]     shift_q;
    logic [7:0]     tx_q;
    logic [7:0]     ptr_q;
    logic           nack_q;
    logic           byte_done;
    logic           wr_stb;
    logic [7:0]     rd_data;
    logic [7:0]     ctrl1_q;
    logic [7:0]     ctrl2_q;

    assign byte_done = scl_fall & (cnt_q == BITS_PER_BYTE);
    // commit on the falling edge that ends the last data bit
    assign wr_stb    = byte_done & (state_q == ST_WDATA);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                state_d = ST_IDLE;
            ST_ADDR:
            begin
                // 10-bit headers and general call never equal own address
                if (byte_done)
                begin
                    if (shift_q[7:1] == own_addr)
                        state_d = ST_ACK_ADDR;
                    else
                        state_d = ST_IDLE;
                end
            end
            ST_ACK_ADDR:
            begin
                if (scl_fall)
                    state_d = shift_q[0] ? ST_TX : ST_REG;
            end
            ST_REG:
            begin
                if (byte_done)
                    state_d = ST_ACK_REG;
            end
            ST_ACK_REG:
            begin
                if (scl_fall)
                    state_d = ST_WDATA;
            end
            ST_WDATA:
            begin
                if (byte_done)
                    state_d = ST_ACK_DATA;
            end
            ST_ACK_DATA:
            begin
                if (scl_fall)
                    state_d = ST_WDATA;
            end
            ST_TX:
            begin
                if (byte_done)
                    state_d = ST_MACK;
            end
            ST_MACK:
            begin
                // master nack ends the read
                if (scl_fall)
                    state_d = nack_q ? ST_IDLE : ST_TX;
            end
            default:
                state_d = ST_IDLE;
        endcase
        if (stop_det)
            state_d = ST_IDLE;
        if (start_det)
            state_d = ST_ADDR;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // bit counter: counts rising SCL edges within a byte
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 4'h0;
        else if (start_det || (state_q != state_d))
            cnt_q <= 4'h0;
        else if (scl_rise && (cnt_q != BITS_PER_BYTE))
            cnt_q <= cnt_q + 4'h1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            shift_q <= 8'h00;
        else if (scl_rise && (cnt_q != BITS_PER_BYTE)
                 && (state_q inside {ST_ADDR, ST_REG, ST_WDATA}))
            shift_q <= {shift_q[6:0], sda_s};
    end

    // register pointer: set by the register address byte, steps per byte
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ptr_q <= 8'h00;
        else if (byte_done && (state_q == ST_REG))
            ptr_q <= shift_q;
        else if (wr_stb || (scl_fall && (state_q == ST_MACK)))
            ptr_q <= ptr_q + 8'h01;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            nack_q <= 1'b1;
        else if (scl_rise && (state_q == ST_MACK))
            nack_q <= sda_s;
    end

    // ==========================================================
    // read data
    always_comb
    begin
        case (ptr_q)
            REG_CTRL1_OFFSET:  rd_data = ctrl1_q;
            REG_CTRL2_OFFSET:  rd_data = ctrl2_q;
            REG_STATUS_OFFSET: rd_data = {1'b0, status_in};
            default:           rd_data = 8'h00;
        endcase
    end

    // transmit shifter: msb first, loaded when a read byte begins
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            tx_q <= 8'hff;
        else if ((state_d == ST_TX) && (state_q != ST_TX))
            tx_q <= rd_data;
        else if (scl_fall && (state_q == ST_TX))
            tx_q <= {tx_q[6:0], 1'b1};
    end

    // ==========================================================
    // sda drive: pull low for acks and zero data bits
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sda_oe <= 1'b0;
        else
        begin
            case (state_d)
                ST_ACK_ADDR, ST_ACK_REG, ST_ACK_DATA:
                    sda_oe <= 1'b1;
                ST_TX:
                    sda_oe <= ((state_q != ST_TX) ? ~rd_data[7] :
                               (scl_fall ? ~tx_q[6] : ~tx_q[7]));
                default:
                    sda_oe <= 1'b0;
            endcase
        end
    end

    assign sda_out = 1'b0;

    // ==========================================================
    // configuration registers, writable whatever the enable pin
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl1_q <= CTRL1_RESET;
        else if (wr_stb && (ptr_q == REG_CTRL1_OFFSET))
            ctrl1_q <= shift_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl2_q <= CTRL2_RESET;
        else if (wr_stb && (ptr_q == REG_CTRL2_OFFSET))
            ctrl2_q <= shift_q;
    end

    assign ctrl1_value           = ctrl1_q;
    assign ctrl2_value           = ctrl2_q;
    assign control_source_select = ctrl1_q[CTRL1_SRC_BIT];

    // ==========================================================
    // output control
    lnbc_output_select u_out_sel
    (
        .ref_clk                 (ref_clk),
        .rst_n                   (rst_n),
        .enable_pin              (en_s),
        .scl_level               (scl_s),
        .voltage_select_pin      (vsel_s),
        .control_source_select   (ctrl1_q[CTRL1_SRC_BIT]),
        .reg_enable              (ctrl2_q[CTRL2_EN_BIT]),
        .reg_code                (ctrl1_q[CTRL1_CODE_LSB +: CODE_W]),
        .regulated_output_enable (regulated_output_enable),
        .output_voltage_code     (output_voltage_code)
    );

endmodule

`default_nettype wire

// ==== dv/lnbc_i2c_top_props.sv ====
`timescale 1ns/100ps
`default_nettype none

module lnbc_i2c_top_props
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       sda_out,
    input  wire logic       sda_oe,
    input  wire logic       enable_pin,
    input  wire logic       voltage_select_pin,
    input  wire logic [1:0] address_pin_level,
    input  wire logic [6:0] status_in,
    input  wire logic       regulated_output_enable,
    input  wire logic [3:0] output_voltage_code,
    input  wire logic       control_source_select,
    input  wire logic [7:0] ctrl1_value,
    input  wire logic [7:0] ctrl2_value
);
    import lnbc_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic [3:0] pin_code;
    assign pin_code = scl_in ? (voltage_select_pin ? CODE_PIN_HH : CODE_PIN_HL)
                             : (voltage_select_pin ? CODE_PIN_LH : CODE_PIN_LL);

    // ==========================================================
    // output control
    a_pin_enable: assert property ((!control_source_select && $stable(enable_pin))[*5]
        |-> regulated_output_enable == enable_pin) else $error("enable not following pin");
    a_pin_code: assert property ((!control_source_select && enable_pin
        && $stable({scl_in, voltage_select_pin}))[*5] |-> output_voltage_code == pin_code)
        else $error("pin level code wrong");
    a_reg_enable: assert property ((control_source_select && $stable(ctrl2_value))[*2]
        |-> regulated_output_enable == ctrl2_value[CTRL2_EN_BIT])
        else $error("enable not following register");
    a_reg_code: assert property ((control_source_select && $stable(ctrl1_value))[*2]
        |-> output_voltage_code == ctrl1_value[CTRL1_CODE_LSB +: CODE_W])
        else $error("code not following register");
    a_reset_values: assert property ($rose(rst_n) |-> !control_source_select
        && ctrl1_value == CTRL1_RESET && ctrl2_value[CTRL2_EN_BIT])
        else $error("bad values after reset");

    // ==========================================================
    // output after reset and serial side
    a_off_after_reset: assert property ($rose(rst_n) && !enable_pin
        |-> (!regulated_output_enable)[*4]) else $error("output on after reset with pin low");
    a_ack_stable: assert property (scl_in[*3] |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    a_od_low: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data driven high");
    a_commit_low: assert property (!$stable({ctrl1_value, ctrl2_value})
        |-> !scl_in && !$past(scl_in) && !$past(scl_in, 2))
        else $error("register changed outside clock low");

    cover property ($rose(control_source_select));
    cover property ($rose(sda_oe));
    cover property ($fell(regulated_output_enable));
endmodule

bind lnbc_i2c_top lnbc_i2c_top_props u_props
(
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
    .voltage_select_pin(voltage_select_pin), .address_pin_level(address_pin_level),
    .status_in(status_in), .regulated_output_enable(regulated_output_enable),
    .output_voltage_code(output_voltage_code), .control_source_select(control_source_select),
    .ctrl1_value(ctrl1_value), .ctrl2_value(ctrl2_value)
);

`default_nettype wire

// ==== dv/lnbc_i2c_master.sv ====
`timescale 1ns/100ps
`default_nettype none

module lnbc_i2c_master
(
    input  wire logic ref_clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_m
);
    int ph = 4;

    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic set_scl(input logic b);
        wt(1);
        scl = b;
    endtask

    // start or repeated start
    task automatic start();
        sda_m = 1'b1;
        wt(ph);
        scl = 1'b1;
        wt(ph);
        sda_m = 1'b0;
        wt(ph);
        scl = 1'b0;
    endtask

    task automatic stop();
        wt(2);
        sda_m = 1'b0;
        wt(ph);
        scl = 1'b1;
        wt(ph);
        sda_m = 1'b1;
        wt(ph);
    endtask

    task automatic bit_io(input logic b, output logic r);
        wt(2);
        sda_m = b;
        wt(ph - 2);
        scl = 1'b1;
        wt(ph / 2);
        r = sda;
        wt(ph / 2);
        scl = 1'b0;
    endtask

    // msb first, then the acknowledge clock
    task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q,
                           output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ai, ack);
    endtask

    task automatic write_reg(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                             output logic ok);
        logic [7:0] q;
        logic       k0;
        logic       k1;
        logic       k2;
        start();
        byte_io({a, 1'b0}, 1'b1, q, k0);
        byte_io(r, 1'b1, q, k1);
        byte_io(d, 1'b1, q, k2);
        stop();
        ok = !(k0 | k1 | k2);
    endtask

    task automatic read_reg(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d);
        logic [7:0] q;
        logic       k;
        start();
        byte_io({a, 1'b0}, 1'b1, q, k);
        byte_io(r, 1'b1, q, k);
        start();
        byte_io({a, 1'b1}, 1'b1, q, k);
        byte_io(8'hff, 1'b1, d, k);
        stop();
    endtask
endmodule

`default_nettype wire

// ==== dv/lnbc_i2c_top_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module lnbc_i2c_top_tb_top;
    import lnbc_pkg::*;

    logic       ref_clk = 1'b0;
    logic       rst_n;
    logic       scl;
    logic       sda_m;
    logic       sda;
    logic       sda_out;
    logic       sda_oe;
    logic       enable_pin;
    logic       vsel;
    logic [1:0] addr_lvl;
    logic [6:0] status;
    logic       reo;
    logic [3:0] code;
    logic       css;
    logic [7:0] c1;
    logic [7:0] c2;
    int         n_errors = 0;
    int         num_checks = 0;
    logic [3:0] pin_code [4] = '{4'h4, 4'hc, 4'h6, 4'he};
    logic [6:0] addrs [4] = '{7'h08, 7'h09, 7'h10, 7'h11};
    logic [6:0] bad [3] = '{7'h10, 7'h00, 7'h78};

    assign sda = ~sda_oe & sda_m;
    always #25 ref_clk = ~ref_clk;

    lnbc_i2c_top u_dut
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .enable_pin(enable_pin), .voltage_select_pin(vsel),
        .address_pin_level(addr_lvl), .status_in(status), .regulated_output_enable(reo),
        .output_voltage_code(code), .control_source_select(css), .ctrl1_value(c1),
        .ctrl2_value(c2)
    );

    lnbc_i2c_master u_mst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_m(sda_m));

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // tests
    initial
    begin
        logic [7:0] d;
        logic       k;
        rst_n = 1'b0;
        enable_pin = 1'b0;
        vsel = 1'b0;
        addr_lvl = 2'h0;
        status = 7'h00;
        repeat (4) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        u_mst.wt(4);
        check("ctrl1", c1, 8'h08);
        check("ctrl2", c2, 8'h09);
        check("src", 8'(css), 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            u_mst.set_scl(i[1]);
            vsel = i[0];
            enable_pin = 1'b1;
            u_mst.wt(6);
            check("pin code", 8'(code), 8'(pin_code[i]));
            check("pin on", 8'(reo), 8'h01);
            enable_pin = 1'b0;
            u_mst.wt(6);
            check("pin off", 8'(reo), 8'h00);
        end
        u_mst.set_scl(1'b1);
        for (int i = 0; i < 4; i++)
        begin
            addr_lvl = 2'(i);
            u_mst.wt(4);
            u_mst.write_reg(addrs[i], 8'h01, 8'(8'h10 + i), k);
            check("ack", 8'(k), 8'h01);
            check("ctrl2 wr", c2, 8'(8'h10 + i));
        end
        foreach (bad[j])
        begin
            u_mst.write_reg(bad[j], 8'h01, 8'h5a, k);
            check("nack", 8'(k), 8'h00);
        end
        check("ctrl2 kept", c2, 8'h13);
        u_mst.write_reg(7'h11, 8'h00, 8'h9e, k);
        u_mst.wt(2);
        check("src on", 8'(css), 8'h01);
        check("code top", 8'(code), 8'h0f);
        check("reg off", 8'(reo), 8'h00);
        u_mst.write_reg(7'h11, 8'h00, 8'h8a, k);
        u_mst.write_reg(7'h11, 8'h01, 8'h08, k);
        u_mst.wt(2);
        check("reg on", 8'(reo), 8'h01);
        check("reg code", 8'(code), 8'h05);
        enable_pin = 1'b1;
        vsel = 1'b1;
        u_mst.ph = 16;
        u_mst.write_reg(7'h11, 8'h01, 8'h00, k);
        check("slow ack", 8'(k), 8'h01);
        u_mst.ph = 4;
        u_mst.wt(2);
        check("reg off pin on", 8'(reo), 8'h00);
        check("pins ignored", 8'(code), 8'h05);
        status = 7'h55;
        u_mst.read_reg(7'h11, 8'h00, d);
        check("rd ctrl1", d, 8'h8a);
        u_mst.read_reg(7'h11, 8'h02, d);
        check("rd status", d, 8'h55);
        u_mst.read_reg(7'h11, 8'h05, d);
        check("rd unmapped", d, 8'h00);
        test_done();
    end

    initial
    begin
        #3000000;
        n_errors++;
        test_done();
    end
endmodule

`default_nettype wire
